// File: design/csv_core.sv
// Program counter, stack pointers, vectors and operand addressing.
// Assumes data RAM with combinational read; a command is taken when
// cmd_valid is high and busy is low.
// Notes on behaviour
// - Reset loads the program counter with address zero.
// - Bus-reset interrupt acknowledge branches to 0x0002.
// - Short timer vectors to 0x0004, long timer to 0x0006.
// - Endpoint interrupts 0..4 vector to 0x0008..0x0010 in steps of two.
// - Converter 0x0014, GPIO 0x0016, two-wire 0x0018; slot 0x0012 unused.
// - Application code starts at 0x001A, above the vector table.
// - Usable program memory ends at 0x1FDF.
// - Program stack pointer clears on reset and grows upward.
// - Program stack pointer is written from accumulator, never read back.
// - Interrupt entry clears enable, saves two bytes with post-increment.
// - Interrupt return pre-decrements twice, restores, re-enables.
// - Call saves counter and flags, pointer advances by two.
// - Subroutine return restores counter only, pointer drops by two.
// - Data space is 256 bytes of RAM.
// - Push pre-decrements data stack pointer then writes.
// - Pop reads at data stack pointer then post-increments.
// - Data stack pointer clears on reset.
// - Push at pointer zero wraps and writes address 0xFF.
// - Swap exchanges accumulator and data stack pointer.
// - Immediate mode takes the second instruction byte as operand.
// - Direct mode reads RAM at the one-byte address given.
// - Indexed mode reads RAM at constant plus index register.
// - Fetch advances low eight bits; page op advances upper six.
// - Reset entry pushes nothing onto the program stack.
`timescale 1ns/1ps
module csv_core
  import csv_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             cmd_valid,
  input  wire csv_cmd_t         cmd,
  input  wire logic [7:0]       cmd_data,
  input  wire logic [PC_W-1:0]  cmd_target,
  input  wire logic [3:0]       irq_sel,
  input  wire logic [7:0]       acc_in,
  input  wire logic [7:0]       index_in,
  input  wire logic             alu_flags_we,
  input  wire logic             alu_carry,
  input  wire logic             alu_zero,
  input  wire logic [7:0]       ram_rdata,
  output logic                  busy,
  output logic [7:0]            ram_addr,
  output logic [7:0]            ram_wdata,
  output logic                  ram_we,
  output logic                  ram_re,
  output logic [PC_W-1:0]       program_counter,
  output logic [7:0]            acc_out,
  output logic [7:0]            operand,
  output logic                  carry,
  output logic                  zero,
  output logic                  int_enable,
  output logic                  pc_in_vectors,
  output logic                  pc_beyond_end
);

  typedef struct packed {
    csv_state_t      st;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] tgt;
    logic [7:0]      pstk;
    logic [7:0]      dsp;
    logic [7:0]      acc;
    logic [7:0]      opnd;
    logic            carry;
    logic            zero;
    logic            ie;
    logic            irq_ret;
  } csv_regs_t;

  csv_regs_t r;
  csv_regs_t next_r;
  logic      take;

  // One step up or down on an 8-bit pointer, wrapping modulo 256
  function automatic logic [7:0] step8(input logic [7:0] v,
                                       input logic up);
    return up ? 8'(v + 8'h01) : 8'(v - 8'h01);
  endfunction

  // Vector address of an interrupt source
  function automatic logic [PC_W-1:0] vector_of(input logic [3:0] s);
    logic [PC_W-1:0] v;
    v = RESET_VEC;
    if (s == SEL_BUSRST) v = VEC_BUSRST;
    else if (s == SEL_TMR_SHORT) v = VEC_TMR_SHORT;
    else if (s == SEL_TMR_LONG) v = VEC_TMR_LONG;
    else if (s >= SEL_EP0 && s <= SEL_EP4)
      v = 14'(VEC_EP_BASE + VEC_STEP * 14'(s - SEL_EP0));
    else if (s == SEL_CONV) v = VEC_CONV;
    else if (s == SEL_GPIO) v = VEC_GPIO;
    else if (s == SEL_TWI) v = VEC_TWI;
    return v;
  endfunction

  assign take = cmd_valid && (r.st == ST_IDLE);

  // Next-state logic; RAM strobes are combinational so a data stack access
  // completes in the cycle its command is taken.
  always_comb begin
    next_r    = r;
    ram_addr  = PTR_RESET;
    ram_wdata = PTR_RESET;
    ram_we    = 1'b0;
    ram_re    = 1'b0;
    if (alu_flags_we) begin
      next_r.carry = alu_carry;
      next_r.zero  = alu_zero;
    end
    unique case (r.st)
      ST_IDLE: begin
        if (cmd_valid) begin
          unique case (cmd)
            CMD_FETCH:
              next_r.pc[PAGE_LSB-1:0] = step8(r.pc[PAGE_LSB-1:0], 1'b1);
            CMD_PAGE: begin
              next_r.pc[PC_W-1:PAGE_LSB] =
                6'(r.pc[PC_W-1:PAGE_LSB] + 6'h01);
              next_r.pc[PAGE_LSB-1:0] = step8(r.pc[PAGE_LSB-1:0], 1'b1);
            end
            CMD_JUMP: next_r.pc = cmd_target;
            CMD_CALL: begin
              next_r.tgt = cmd_target;
              next_r.st  = ST_SAVE1;
            end
            CMD_IRQ: begin
              next_r.ie  = 1'b0;
              next_r.tgt = vector_of(irq_sel);
              next_r.st  = ST_SAVE1;
            end
            CMD_SUB_RETURN, CMD_IRQ_RETURN: begin
              ram_re   = 1'b1;
              ram_addr = step8(r.pstk, 1'b0);
              next_r.pstk = ram_addr;
              next_r.tgt[PAGE_LSB-1:0] = ram_rdata;
              next_r.irq_ret = (cmd == CMD_IRQ_RETURN);
              next_r.st  = ST_LOAD1;
            end
            CMD_PUSH: begin
              ram_we    = 1'b1;
              ram_addr  = step8(r.dsp, 1'b0);
              ram_wdata = cmd_data;
              next_r.dsp = ram_addr;
            end
            CMD_POP: begin
              ram_re     = 1'b1;
              ram_addr   = r.dsp;
              next_r.acc = ram_rdata;
              next_r.dsp = step8(r.dsp, 1'b1);
            end
            CMD_SWAP: begin
              next_r.dsp = acc_in;
              next_r.acc = r.dsp;
            end
            // Write-only: no path returns the pointer to software
            CMD_SET_STACK: next_r.pstk = acc_in;
            CMD_LD_IMM: next_r.opnd = cmd_data;
            CMD_LD_DIR: begin
              ram_re      = 1'b1;
              ram_addr    = cmd_data;
              next_r.opnd = ram_rdata;
            end
            CMD_LD_IDX: begin
              ram_re      = 1'b1;
              ram_addr    = 8'(cmd_data + index_in);
              next_r.opnd = ram_rdata;
            end
            default: ;                                   // Flags still load
          endcase
        end
      end
      // First saved byte: flags and upper counter bits
      ST_SAVE1: begin
        ram_we    = 1'b1;
        ram_addr  = r.pstk;
        ram_wdata = {r.carry, r.zero, r.pc[PC_W-1:PAGE_LSB]};
        next_r.pstk = step8(r.pstk, 1'b1);
        next_r.st  = ST_SAVE2;
      end
      // Second saved byte: lower counter bits, then branch
      ST_SAVE2: begin
        ram_we    = 1'b1;
        ram_addr  = r.pstk;
        ram_wdata = r.pc[PAGE_LSB-1:0];
        next_r.pstk = step8(r.pstk, 1'b1);
        next_r.pc  = r.tgt;
        next_r.st  = ST_IDLE;
      end
      // Restore the first byte; flags only on interrupt return
      ST_LOAD1: begin
        ram_re   = 1'b1;
        ram_addr = step8(r.pstk, 1'b0);
        next_r.pstk = ram_addr;
        next_r.pc = {ram_rdata[PC_W-PAGE_LSB-1:0], r.tgt[PAGE_LSB-1:0]};
        if (r.irq_ret) begin
          next_r.carry = ram_rdata[SAVE_CARRY];
          next_r.zero  = ram_rdata[SAVE_ZERO];
          next_r.ie    = 1'b1;
        end
        next_r.st = ST_IDLE;
      end
    endcase
  end

  // Reset enters at address zero without touching the stack
  always_ff @(posedge clock) begin
    if (reset) begin
      r       <= '0;
      r.pc    <= RESET_VEC;
      r.pstk  <= PTR_RESET;
      r.dsp   <= PTR_RESET;
      r.st    <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from state
  assign busy            = (r.st != ST_IDLE);
  assign program_counter = r.pc;
  assign acc_out         = r.acc;
  assign operand         = r.opnd;
  assign carry           = r.carry;
  assign zero            = r.zero;
  assign int_enable      = r.ie;
  assign pc_in_vectors   = (r.pc < CODE_BASE);
  assign pc_beyond_end   = (r.pc > PROG_END);

  a_reset_state: assert property (@(posedge clock)
    $fell(reset) |-> program_counter == RESET_VEC && r.pstk == PTR_RESET
      && r.dsp == PTR_RESET && !busy)
    else $error("State not cleared by reset");

  // A reset cut into a save must not leave the save sequence running
  a_reset_quiet: assert property (@(posedge clock)
    reset |=> !busy && r.pstk == PTR_RESET)
    else $error("Reset entry started a stack save");

  a_irq_vector: assert property (
    @(posedge clock) disable iff (reset)
    take && cmd == CMD_IRQ |-> ##3
      program_counter == vector_of($past(irq_sel, 3)) && !busy)
    else $error("Interrupt did not branch to its vector");

  a_irq_save: assert property (
    @(posedge clock) disable iff (reset)
    take && cmd == CMD_IRQ |=> !int_enable ##0 ram_we [*2] ##1
      r.pstk == 8'($past(r.pstk, 3) + 8'h02))
    else $error("Interrupt entry save sequence wrong");

  a_call_save: assert property (
    @(posedge clock) disable iff (reset)
    take && cmd == CMD_CALL |=> ram_we && ram_addr == $past(r.pstk)
      ##1 ram_we ##1 r.pstk == 8'($past(r.pstk, 3) + 8'h02)
      && program_counter == $past(cmd_target, 3))
    else $error("Call did not save two bytes and branch");

  a_return_from_interrupt_op_restore: assert property (
    @(posedge clock) disable iff (reset)
    take && cmd == CMD_IRQ_RETURN |-> ##2
      int_enable && r.pstk == 8'($past(r.pstk, 2) - 8'h02))
    else $error("Interrupt return did not restore");

  a_ret_flags: assert property (
    @(posedge clock) disable iff (reset)
    take && cmd == CMD_SUB_RETURN && !alu_flags_we ##1 !alu_flags_we |=>
      carry == $past(carry, 2) && zero == $past(zero, 2))
    else $error("Subroutine return touched the flags");

  a_push_pre: assert property (
    @(posedge clock) disable iff (reset)
    take && cmd == CMD_PUSH |-> ram_we && ram_wdata == cmd_data
      && ram_addr == 8'(r.dsp - 8'h01) ##1 r.dsp == $past(ram_addr))
    else $error("Push did not pre-decrement then write");

  a_push_wrap: assert property (
    @(posedge clock) disable iff (reset)
    take && cmd == CMD_PUSH && r.dsp == PTR_RESET |->
      ram_we && ram_addr == DATA_TOP ##1 r.dsp == DATA_TOP)
    else $error("Push at zero did not wrap");

  a_pop_post: assert property (
    @(posedge clock) disable iff (reset)
    take && cmd == CMD_POP |-> ram_re && ram_addr == r.dsp ##1
      r.dsp == 8'($past(r.dsp) + 8'h01) && acc_out == $past(ram_rdata))
    else $error("Pop did not read then increment");

  a_swap_xchg: assert property (
    @(posedge clock) disable iff (reset)
    take && cmd == CMD_SWAP |=> acc_out == $past(r.dsp)
      && r.dsp == $past(acc_in))
    else $error("Swap did not exchange pointer and accumulator");

  a_direct_read: assert property (
    @(posedge clock) disable iff (reset)
    take && cmd == CMD_LD_DIR |-> ram_re && ram_addr == cmd_data
      ##1 operand == $past(ram_rdata))
    else $error("Direct operand not read from its address");

  a_index_wrap: assert property (
    @(posedge clock) disable iff (reset)
    take && cmd == CMD_LD_IDX |-> ram_addr == 8'(cmd_data + index_in)
      ##1 operand == $past(ram_rdata))
    else $error("Indexed address not wrapped sum");

  a_fetch_page: assert property (
    @(posedge clock) disable iff (reset)
    take && cmd == CMD_FETCH |=> program_counter[PC_W-1:PAGE_LSB] ==
      $past(program_counter[PC_W-1:PAGE_LSB]))
    else $error("Fetch changed the page bits");

endmodule // csv_core

// File: design/csv_pkg.sv
// Package for the stack, vector and operand address core.
// Assumes a 14-bit program space and a 256-byte data RAM.
package csv_pkg;

  localparam int PC_W   = 14;
  localparam int DATA_W = 8;

  // Program memory map
  localparam logic [13:0] RESET_VEC = 14'h0000;
  localparam logic [13:0] VEC_BUSRST = 14'h0002;
  localparam logic [13:0] VEC_TMR_SHORT = 14'h0004;
  localparam logic [13:0] VEC_TMR_LONG = 14'h0006;
  localparam logic [13:0] VEC_EP_BASE = 14'h0008;
  localparam logic [13:0] VEC_CONV = 14'h0014;
  localparam logic [13:0] VEC_GPIO = 14'h0016;
  localparam logic [13:0] VEC_TWI = 14'h0018;
  localparam logic [13:0] CODE_BASE = 14'h001A;
  localparam logic [13:0] PROG_END = 14'h1FDF;
  localparam logic [13:0] VEC_STEP = 14'h0002;

  // Interrupt source selectors
  localparam logic [3:0] SEL_BUSRST = 4'h0;
  localparam logic [3:0] SEL_TMR_SHORT = 4'h1;
  localparam logic [3:0] SEL_TMR_LONG = 4'h2;
  localparam logic [3:0] SEL_EP0 = 4'h3;
  localparam logic [3:0] SEL_EP4 = 4'h7;
  localparam logic [3:0] SEL_CONV = 4'h8;
  localparam logic [3:0] SEL_GPIO = 4'h9;
  localparam logic [3:0] SEL_TWI = 4'hA;

  // Pointer values and byte layout of the saved word
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] DATA_TOP = 8'hFF;
  localparam int SAVE_CARRY = 7;
  localparam int SAVE_ZERO = 6;
  localparam int PAGE_LSB = 8;

  typedef enum logic [3:0] {
    CMD_FETCH      = 4'h0,
    CMD_PAGE       = 4'h1,
    CMD_JUMP       = 4'h2,
    CMD_CALL       = 4'h3,
    CMD_IRQ        = 4'h4,
    CMD_SUB_RETURN = 4'h5,
    CMD_IRQ_RETURN = 4'h6,
    CMD_PUSH       = 4'h7,
    CMD_POP        = 4'h8,
    CMD_SWAP       = 4'h9,
    CMD_SET_STACK  = 4'hA,
    CMD_LD_IMM     = 4'hB,
    CMD_LD_DIR     = 4'hC,
    CMD_LD_IDX     = 4'hD
  } csv_cmd_t;

  // One-bit steps except save second -> idle: idle -> save first -> save second -> idle; idle -> load
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SAVE1 = 2'b01,
    ST_SAVE2 = 2'b11,
    ST_LOAD1 = 2'b10
  } csv_state_t;

endpackage

// File: verification/csv_ram_model.sv
// Partner model: the 256-byte data RAM that faces the core.
// Assumes a combinational read and a write at the rising clock edge.
`timescale 1ns/1ps
module csv_ram_model (
  input  wire logic       clock,
  input  wire logic [7:0] ram_addr,
  input  wire logic [7:0] ram_wdata,
  input  wire logic       ram_we,
  input  wire logic       ram_re,
  output logic      [7:0] ram_rdata
);
  logic [7:0] mem [256];
  // Known fill, so a stray write or a missing one shows up
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
  // Unread cycles show inverted data, so a stale value never matches
  assign ram_rdata = ram_re ? mem[ram_addr] : ~mem[ram_addr];
  // Write lands at the edge that ends the strobe cycle
  always @(posedge clock) if (ram_we) mem[ram_addr] <= ram_wdata;
endmodule // csv_ram_model

// File: verification/cpu_stack_vector_addressing_bench.sv
// Self-checking bench for the stack, vector and addressing core.
// Assumes csv_pkg and csv_ram_model; an integer model predicts results.
`timescale 1ns/1ps
module cpu_stack_vector_addressing_bench;
  import csv_pkg::*;
  logic            clock = 1'b0;
  logic            reset;
  logic            cmd_valid = 1'b0;
  csv_cmd_t        cmd = CMD_FETCH;
  logic [7:0]      cmd_data = 8'h00;
  logic [PC_W-1:0] cmd_target = 14'h0000;
  logic [3:0]      irq_sel = 4'h0;
  logic [7:0]      acc_in = 8'h00;
  logic [7:0]      index_in = 8'h00;
  logic            alu_flags_we = 1'b0;
  logic            alu_carry = 1'b0;
  logic            alu_zero = 1'b0;
  logic [7:0]      ram_rdata, ram_addr, ram_wdata, acc_out, operand;
  logic [PC_W-1:0] program_counter;
  logic            busy, ram_we, ram_re, carry, zero, int_enable;
  logic            pc_in_vectors, pc_beyond_end;
  int              error_cnt = 0;
  int              checked = 0;
  int              m_pc, m_pstk, m_dsp, m_acc, m_opd, m_c, m_z, m_ie;
  int              m_mem [256];

  // 10 MHz clock
  always #50 clock = ~clock;

  csv_core i_csv_core (.clock(clock), .reset(reset),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_data(cmd_data),
    .cmd_target(cmd_target), .irq_sel(irq_sel), .acc_in(acc_in),
    .index_in(index_in), .alu_flags_we(alu_flags_we),
    .alu_carry(alu_carry), .alu_zero(alu_zero), .ram_rdata(ram_rdata),
    .busy(busy), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_re(ram_re), .program_counter(program_counter),
    .acc_out(acc_out), .operand(operand), .carry(carry), .zero(zero),
    .int_enable(int_enable), .pc_in_vectors(pc_in_vectors),
    .pc_beyond_end(pc_beyond_end));

  csv_ram_model i_csv_ram_model (.clock(clock), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re),
    .ram_rdata(ram_rdata));

  // Verdict and end of run
  task automatic final_report();
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Comparisons, one per kind of result
  task automatic chk14(string nm, logic [13:0] e, logic [13:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk1(string nm, logic e, logic s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %b seen %b", nm, e, s);
    end
  endtask

  // Vector table, slot 0x0012 skipped
  function automatic int vec(int s);
    if (s <= 7) return 2 + 2 * s;
    if (s <= 10) return 'h14 + 2 * (s - 8);
    return 0;
  endfunction

  task automatic check_all();
    chk14("pc", 14'(m_pc), program_counter);
    chk8("acc", 8'(m_acc), acc_out);
    chk8("operand", 8'(m_opd), operand);
    chk1("carry", 1'(m_c), carry);
    chk1("zero", 1'(m_z), zero);
    chk1("int_enable", 1'(m_ie), int_enable);
    chk1("vectors", m_pc < 'h1A, pc_in_vectors);
    chk1("beyond", m_pc > 'h1FDF, pc_beyond_end);
  endtask

  // Reset and model clear
  task automatic do_reset(int n);
    reset = 1'b1;
    repeat (n) @(posedge clock);
    #1 reset = 1'b0;
    {m_pc, m_pstk, m_dsp, m_acc, m_opd, m_c, m_z, m_ie} = '0;
    check_all();
  endtask

  // One ALU flag write while idle
  task automatic set_flags();
    alu_carry = 1'($urandom);
    alu_zero = 1'($urandom);
    alu_flags_we = 1'b1;
    @(posedge clock);
    #1 alu_flags_we = 1'b0;
    m_c = alu_carry;
    m_z = alu_zero;
  endtask

  // Request held through busy, so repeats while busy must be ignored
  task automatic issue(csv_cmd_t c, int d, int t);
    int n;
    int a;
    int nb;
    n = 0;
    cmd = c;
    cmd_data = 8'(d);
    cmd_target = 14'(t);
    cmd_valid = 1'b1;
    do begin
      @(posedge clock);
      #1 n++;
    end while (busy !== 1'b0 && n < 8);
    cmd_valid = 1'b0;
    if (n == 8) begin
      error_cnt++;
      $display("unexpected busy expected 0 seen %b", busy);
    end
    // Edges until busy falls: saves hold two extra, restores one
    nb = (c == CMD_CALL || c == CMD_IRQ) ? 3 :
         (c == CMD_SUB_RETURN || c == CMD_IRQ_RETURN) ? 2 : 1;
    chk8("busy_edges", 8'(nb), 8'(n));
    case (c)
      CMD_FETCH: m_pc = m_pc / 256 * 256 + (m_pc + 1) % 256;
      CMD_PAGE: m_pc = (m_pc / 256 + 1) % 64 * 256 + (m_pc + 1) % 256;
      CMD_JUMP: m_pc = t;
      CMD_CALL, CMD_IRQ: begin
        if (c == CMD_IRQ) t = vec(irq_sel);
        if (c == CMD_IRQ) m_ie = 0;
        a = (m_pstk + 1) % 256;
        m_mem[m_pstk] = m_c * 128 + m_z * 64 + m_pc / 256;
        m_mem[a] = m_pc % 256;
        chk8("save_hi", 8'(m_mem[m_pstk]),
          i_csv_ram_model.mem[m_pstk]);
        chk8("save_lo", 8'(m_mem[a]), i_csv_ram_model.mem[a]);
        m_pstk = (m_pstk + 2) % 256;
        m_pc = t;
      end
      CMD_SUB_RETURN, CMD_IRQ_RETURN: begin
        a = m_mem[(m_pstk + 254) % 256];
        m_pc = a % 64 * 256 + m_mem[(m_pstk + 255) % 256];
        if (c == CMD_IRQ_RETURN) begin
          m_c = a / 128;
          m_z = a / 64 % 2;
          m_ie = 1;
        end
        m_pstk = (m_pstk + 254) % 256;
      end
      CMD_PUSH: begin
        m_dsp = (m_dsp + 255) % 256;
        m_mem[m_dsp] = d;
        chk8("pushed", 8'(d), i_csv_ram_model.mem[m_dsp]);
      end
      CMD_POP: begin
        m_acc = m_mem[m_dsp];
        m_dsp = (m_dsp + 1) % 256;
      end
      CMD_SWAP: {m_acc, m_dsp} = {m_dsp, int'(acc_in)};
      CMD_SET_STACK: m_pstk = acc_in;
      CMD_LD_IMM: m_opd = d;
      CMD_LD_DIR: m_opd = m_mem[d];
      CMD_LD_IDX: m_opd = m_mem[(d + index_in) % 256];
      default: ;
    endcase
    check_all();
    @(posedge clock);
    #1;
  endtask

  // Main sequence
  initial begin
    void'($urandom(76));
    for (int i = 0; i < 256; i++) m_mem[i] = i ^ 'hA5;
    do_reset(20);
    chk8("ram0", 8'hA5, i_csv_ram_model.mem[0]);
    set_flags();
    issue(CMD_JUMP, 0, 'h1FDE);
    for (int s = 0; s < 12; s++) begin
      irq_sel = 4'(s);
      issue(CMD_IRQ, 0, 0);
      issue(CMD_FETCH, 0, 0);
      issue(CMD_IRQ_RETURN, 0, 0);
      set_flags();
    end
    acc_in = 8'($urandom);
    issue(CMD_SET_STACK, 0, 0);
    issue(CMD_CALL, 0, 'h0123);
    issue(CMD_IRQ, 0, 0);
    issue(CMD_IRQ_RETURN, 0, 0);
    set_flags();
    issue(CMD_SUB_RETURN, 0, 0);
    issue(CMD_JUMP, 0, 'h02FF);
    issue(CMD_FETCH, 0, 0);
    issue(CMD_JUMP, 0, 'h02FF);
    issue(CMD_PAGE, 0, 0);
    issue(CMD_JUMP, 0, 'h1FE0);
    issue(CMD_PUSH, 'h3C, 0);
    issue(CMD_PUSH, $urandom % 256, 0);
    issue(CMD_POP, 0, 0);
    issue(CMD_POP, 0, 0);
    acc_in = 8'($urandom);
    issue(CMD_SWAP, 0, 0);
    issue(CMD_PUSH, 'h77, 0);
    issue(CMD_SWAP, 0, 0);
    for (int i = 0; i < 8; i++) begin
      index_in = 8'($urandom);
      issue(CMD_LD_IMM, $urandom % 256, 0);
      issue(CMD_LD_DIR, $urandom % 256, 0);
      issue(CMD_LD_IDX, $urandom % 256, 0);
    end
    issue(CMD_PUSH, 'h11, 0);
    do_reset(2);
    issue(CMD_SWAP, 0, 0);
    issue(CMD_CALL, 0, 'h0040);
    final_report();
  end

  // Watchdog: the sequence needs well under 1500 cycles
  initial begin
    #(100 * 4000);
    error_cnt++;
    final_report();
  end
endmodule // cpu_stack_vector_addressing_bench
